// ==== hdl/gdps_defs.svh ====
`ifndef GDPS_DEFS_SVH
`define GDPS_DEFS_SVH
// ports and data path
`define GDPS_NPORT          4
`define GDPS_WORD_W         8
`define GDPS_FIFO_DEPTH     32
// programmer clock
`define GDPS_SYS_HZ         100000000
// lowest supported target clock, in hz
`define GDPS_TGT_MIN_HZ     32000
// recommended target clock, in hz
`define GDPS_TGT_REC_HZ     1000000
// frequency field width, in khz
`define GDPS_FREQ_W         16
// programming clock is at most target clock / this
`define GDPS_TGT_RATIO      4
// power-up window, in seconds
`define GDPS_PWR_WIN_S      10
`define GDPS_PWR_WIN_CYC    (`GDPS_PWR_WIN_S * `GDPS_SYS_HZ)
// reset pulse width at end of cycle, in us
`define GDPS_RST_PULSE_US   10
`define GDPS_RST_PULSE_CYC  (`GDPS_RST_PULSE_US * (`GDPS_SYS_HZ / 1000000))
// device id width
`define GDPS_ID_W           16
`endif

// ==== hdl/gdps_pkg.sv ====
package gdps_pkg;
  typedef enum logic [7:0] {
    GDPS_IDLE   = 8'h01,
    GDPS_PWROFF = 8'h02,
    GDPS_PWRON  = 8'h04,
    GDPS_CHECK  = 8'h08,
    GDPS_PROG   = 8'h10,
    GDPS_RSTPLS = 8'h20,
    GDPS_DONE   = 8'h40,
    GDPS_ERR    = 8'h80
  } gdps_state_e;
  typedef enum logic [1:0] {
    GDPS_OK       = 2'h0,
    GDPS_E_POWER  = 2'h1,
    GDPS_E_ID     = 2'h2,
    GDPS_E_VOLT   = 2'h3
  } gdps_err_e;
endpackage : gdps_pkg

// ==== hdl/gdps_stream_if.sv ====
`timescale 1ns/1ps
`include "gdps_defs.svh"
interface gdps_stream_if;
  logic                      valid;
  logic                      ready;
  logic [`GDPS_WORD_W-1:0]   data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : gdps_stream_if

// ==== hdl/gdps_fifo.sv ====
`timescale 1ns/1ps
module gdps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // streams
  gdps_stream_if.dst wr,
  gdps_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    push  = wr.valid && (cnt_q != DEPTH[AW:0]);
    pop   = rd.ready && (cnt_q != '0);
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end

  assign wr.ready = (cnt_q != DEPTH[AW:0]);
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem[rp_q];

  fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
    cnt_q <= DEPTH[AW:0]) else $error("fifo count over depth");
endmodule : gdps_fifo

// ==== hdl/gdps_seq.sv ====
`timescale 1ns/1ps
`include "gdps_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - hold mode keeps target reset asserted after a successful cycle
// - run mode pulses reset, then releases it
// - bit period derived from target clock, limited
// - supports target clocks down to 32 khz
// - power-on mode starts with target power off
// - start from host or hardware trigger
// - four ports, own debug and reset lines
// - check device id against selected type
// - check target supply at selected level
module gdps_seq #(
  parameter int unsigned PWR_WIN_CYC   = `GDPS_PWR_WIN_CYC,
  parameter int unsigned RST_PULSE_CYC = `GDPS_RST_PULSE_CYC
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  // start requests
  input  wire logic                           host_start,
  input  wire logic                           trig_start_n,
  // configuration
  input  wire logic                           run_mode,
  input  wire logic                           power_on_mode,
  input  wire logic [`GDPS_FREQ_W-1:0]        tgt_khz,
  input  wire logic [`GDPS_NPORT-1:0]         port_en,
  input  wire logic [`GDPS_ID_W-1:0]          expect_id,
  // per-port id and power status
  input  wire logic [`GDPS_NPORT*`GDPS_ID_W-1:0] port_id,
  input  wire logic [`GDPS_NPORT-1:0]         pwr_present,
  input  wire logic [`GDPS_NPORT-1:0]         volt_ok,
  // image stream
  input  wire logic                           img_valid,
  output logic                                img_ready,
  input  wire logic [`GDPS_WORD_W-1:0]        img_data,
  input  wire logic                           img_last,
  // target pins
  output logic [`GDPS_NPORT-1:0]              single_wire_debug_line,
  output logic [`GDPS_NPORT-1:0]              single_wire_debug_line_oe,
  input  wire logic [`GDPS_NPORT-1:0]         single_wire_debug_line_sense,
  output logic [`GDPS_NPORT-1:0]              tgt_reset,
  // status
  output logic                                busy,
  output logic                                done,
  output logic [`GDPS_NPORT-1:0]              port_fail,
  output gdps_pkg::gdps_err_e                 err_code
);
  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [`GDPS_NPORT-1:0] pwr_m_q, pwr_s_q, dbg_m_q, dbg_s_q, volt_m_q, volt_s_q;
  logic                   trg_m_q, trg_s_q, trg_p_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwr_m_q <= '0;
      pwr_s_q <= '0;
      volt_m_q <= '0;
      volt_s_q <= '0;
      dbg_m_q <= '1;
      dbg_s_q <= '1;
      trg_m_q <= 1'b1;
      trg_s_q <= 1'b1;
      trg_p_q <= 1'b1;
    end else begin
      pwr_m_q <= pwr_present;
      pwr_s_q <= pwr_m_q;
      volt_m_q <= volt_ok;
      volt_s_q <= volt_m_q;
      dbg_m_q <= single_wire_debug_line_sense;
      dbg_s_q <= dbg_m_q;
      trg_m_q <= trig_start_n;
      trg_s_q <= trg_m_q;
      trg_p_q <= trg_s_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo in the image path
  gdps_stream_if in_s ();
  gdps_stream_if out_s ();
  assign in_s.valid = img_valid;
  assign in_s.data  = img_data;
  gdps_fifo #(.WIDTH(`GDPS_WORD_W), .DEPTH(`GDPS_FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .reset (reset),
    .wr    (in_s),
    .rd    (out_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bit period from target clock
  // half bit = ratio * sys_hz / tgt_hz; tgt_khz clamped to the 32 khz floor
  function automatic logic [31:0] half_bit(input logic [`GDPS_FREQ_W-1:0] khz);
    logic [31:0] f;
    f = {16'h0000, khz};
    if (f < (`GDPS_TGT_MIN_HZ / 1000)) begin
      f = 32'(`GDPS_TGT_MIN_HZ / 1000);
    end
    return 32'((`GDPS_TGT_RATIO * (`GDPS_SYS_HZ / 1000) + f - 1) / f);
  endfunction : half_bit

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  gdps_pkg::gdps_state_e   st_q, st_d;
  logic [31:0]             tmr_q, tmr_d;
  logic [31:0]             hb_q, hb_d;
  logic [3:0]              bit_q, bit_d;
  logic [`GDPS_WORD_W-1:0] sh_q, sh_d;
  logic                    have_q, have_d;
  logic                    run_q, run_d;
  logic [`GDPS_NPORT-1:0]  en_q, en_d, fail_q, fail_d, rst_q, rst_d, dout_q, dout_d;
  logic                    done_q, done_d;
  gdps_pkg::gdps_err_e     err_q, err_d;
  logic                    start_req, ack_lo;

  always_comb begin
    start_req = host_start || (trg_p_q && !trg_s_q);
    st_d   = st_q;
    tmr_d  = tmr_q;
    hb_d   = hb_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    have_d = have_q;
    run_d  = run_q;
    en_d   = en_q;
    fail_d = fail_q;
    rst_d  = rst_q;
    dout_d = dout_q;
    done_d = 1'b0;
    err_d  = err_q;
    out_s.ready = 1'b0;
    ack_lo = |(en_q & ~dbg_s_q);
    case (st_q)
      gdps_pkg::GDPS_IDLE: begin
        if (start_req && port_en != '0) begin
          en_d   = port_en;
          run_d  = run_mode;
          hb_d   = half_bit(tgt_khz);
          fail_d = '0;
          err_d  = gdps_pkg::GDPS_OK;
          tmr_d  = '0;
          rst_d  = port_en;
          st_d   = power_on_mode ? gdps_pkg::GDPS_PWROFF : gdps_pkg::GDPS_CHECK;
        end
      end
      gdps_pkg::GDPS_PWROFF: begin
        if ((pwr_s_q & en_q) != '0) begin
          fail_d = pwr_s_q & en_q;
          err_d  = gdps_pkg::GDPS_E_POWER;
          st_d   = gdps_pkg::GDPS_ERR;
        end else begin
          st_d = gdps_pkg::GDPS_PWRON;
        end
      end
      gdps_pkg::GDPS_PWRON: begin
        tmr_d = tmr_q + 32'h1;
        if ((pwr_s_q & en_q) == en_q) begin
          tmr_d = '0;
          st_d  = gdps_pkg::GDPS_CHECK;
        end else if (tmr_q >= PWR_WIN_CYC - 1) begin
          fail_d = en_q & ~pwr_s_q;
          err_d  = gdps_pkg::GDPS_E_POWER;
          st_d   = gdps_pkg::GDPS_ERR;
        end
      end
      gdps_pkg::GDPS_CHECK: begin
        for (int p = 0; p < `GDPS_NPORT; p++) begin
          if (en_q[p] && !volt_s_q[p]) begin
            fail_d[p] = 1'b1;
            err_d     = gdps_pkg::GDPS_E_VOLT;
          end else if (en_q[p] && port_id[p*`GDPS_ID_W +: `GDPS_ID_W] != expect_id) begin
            fail_d[p] = 1'b1;
            err_d     = gdps_pkg::GDPS_E_ID;
          end
        end
        st_d  = (err_d != gdps_pkg::GDPS_OK) ? gdps_pkg::GDPS_ERR : gdps_pkg::GDPS_PROG;
        tmr_d = '0;
      end
      gdps_pkg::GDPS_PROG: begin
        if (!have_q) begin
          if (out_s.valid) begin
            out_s.ready = 1'b1;
            sh_d   = out_s.data;
            bit_d  = '0;
            have_d = 1'b1;
            tmr_d  = '0;
          end else if (!img_valid && img_last) begin
            tmr_d = '0;
            rst_d = en_q;
            st_d  = run_q ? gdps_pkg::GDPS_RSTPLS : gdps_pkg::GDPS_DONE;
          end
        end else begin
          tmr_d = tmr_q + 32'h1;
          dout_d = {`GDPS_NPORT{tmr_q < hb_q ? 1'b0 : sh_q[`GDPS_WORD_W-1]}} | ~en_q;
          if (tmr_q >= 2 * hb_q - 1) begin
            tmr_d = '0;
            sh_d  = {sh_q[`GDPS_WORD_W-2:0], 1'b0};
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'(`GDPS_WORD_W - 1)) begin
              have_d = 1'b0;
            end
          end
        end
      end
      gdps_pkg::GDPS_RSTPLS: begin
        rst_d = en_q;
        tmr_d = tmr_q + 32'h1;
        if (tmr_q >= RST_PULSE_CYC - 1) begin
          rst_d = '0;
          st_d  = gdps_pkg::GDPS_DONE;
        end
      end
      gdps_pkg::GDPS_DONE: begin
        done_d = 1'b1;
        dout_d = '1;
        st_d   = gdps_pkg::GDPS_IDLE;
      end
      gdps_pkg::GDPS_ERR: begin
        done_d = 1'b1;
        dout_d = '1;
        rst_d  = '0;
        st_d   = gdps_pkg::GDPS_IDLE;
      end
      default: begin
        st_d = gdps_pkg::GDPS_IDLE;
      end
    endcase
    if (ack_lo && st_q == gdps_pkg::GDPS_IDLE) begin
      dout_d = '1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q   <= gdps_pkg::GDPS_IDLE;
      tmr_q  <= '0;
      hb_q   <= '0;
      bit_q  <= '0;
      sh_q   <= '0;
      have_q <= 1'b0;
      run_q  <= 1'b0;
      en_q   <= '0;
      fail_q <= '0;
      rst_q  <= '0;
      dout_q <= '1;
      done_q <= 1'b0;
      err_q  <= gdps_pkg::GDPS_OK;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      hb_q   <= hb_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      have_q <= have_d;
      run_q  <= run_d;
      en_q   <= en_d;
      fail_q <= fail_d;
      rst_q  <= rst_d;
      dout_q <= dout_d;
      done_q <= done_d;
      err_q  <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  logic                   ready_q, busy_q;
  logic [`GDPS_NPORT-1:0] oe_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ready_q <= 1'b0;
      busy_q  <= 1'b0;
      oe_q    <= '0;
    end else begin
      ready_q <= in_s.ready;
      busy_q  <= (st_d != gdps_pkg::GDPS_IDLE);
      oe_q    <= ~dout_d;
    end
  end
  assign img_ready                 = ready_q;
  assign single_wire_debug_line    = '0;
  assign single_wire_debug_line_oe = oe_q;
  assign tgt_reset                 = rst_q;
  assign busy                      = busy_q;
  assign done                      = done_q;
  assign port_fail                 = fail_q;
  assign err_code                  = err_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  hold_reset_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == gdps_pkg::GDPS_PROG && st_d == gdps_pkg::GDPS_DONE && !run_q)
      |=> ##1 (tgt_reset == en_q)) else $error("hold mode reset dropped");
  run_release_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == gdps_pkg::GDPS_RSTPLS && st_d == gdps_pkg::GDPS_DONE)
      |=> (tgt_reset == '0)) else $error("run mode reset not released");
  bit_period_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == gdps_pkg::GDPS_PROG) |-> (hb_q != '0)) else $error("zero bit period");
  start_power_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == gdps_pkg::GDPS_PWROFF && (pwr_s_q & en_q) != '0)
      |=> (st_q == gdps_pkg::GDPS_ERR)) else $error("powered port not refused");
  power_win_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == gdps_pkg::GDPS_PWRON) |-> (tmr_q < PWR_WIN_CYC)) else $error("power wait overrun");
  start_idle_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == gdps_pkg::GDPS_IDLE && host_start && port_en != '0) |=> busy)
    else $error("start request ignored");
  port_mask_a: assert property (@(posedge clk) disable iff (reset)
    (port_fail & ~en_q) == '0) else $error("failure on disabled port");
  check_fail_a: assert property (@(posedge clk) disable iff (reset)
    (st_q == gdps_pkg::GDPS_CHECK && st_d == gdps_pkg::GDPS_PROG)
      |-> ((en_q & ~volt_s_q) == '0))
    else $error("program after failed check");
endmodule : gdps_seq

// ==== sim/gdps_tgt_model.sv ====
`timescale 1ns/1ps
`include "gdps_defs.svh"
module gdps_tgt_model #(
  parameter int PWR_DLY = 40
) (
  // clock
  input  wire logic                          clk,
  // bench control
  input  wire logic [`GDPS_NPORT-1:0]        pwr_cmd,
  input  wire logic [`GDPS_NPORT-1:0]        bad_id,
  input  wire logic [`GDPS_NPORT-1:0]        bad_volt,
  input  wire logic [`GDPS_ID_W-1:0]         id_val,
  // target pins
  input  wire logic [`GDPS_NPORT-1:0]        line_oe,
  output logic [`GDPS_NPORT-1:0]             line_sense,
  output logic [`GDPS_NPORT-1:0]             pwr_present,
  output logic [`GDPS_NPORT-1:0]             volt_ok,
  output logic [`GDPS_NPORT*`GDPS_ID_W-1:0]  port_id
);
  int cnt [`GDPS_NPORT];
  // pull-up on debug line, target reset pins left open
  assign line_sense = ~line_oe;
  assign volt_ok = pwr_present & ~bad_volt;
  always_comb begin
    for (int p = 0; p < `GDPS_NPORT; p++) begin
      port_id[p*`GDPS_ID_W +: `GDPS_ID_W] = bad_id[p] ? ~id_val : id_val;
    end
  end
  // supply settles PWR_DLY + 1 cycles after switch-on
  always_ff @(posedge clk) begin
    for (int p = 0; p < `GDPS_NPORT; p++) begin
      cnt[p]         <= pwr_cmd[p] ? ((cnt[p] < PWR_DLY) ? cnt[p] + 1 : cnt[p]) : 0;
      pwr_present[p] <= pwr_cmd[p] && (cnt[p] >= PWR_DLY);
    end
  end
endmodule : gdps_tgt_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`include "gdps_defs.svh"
module tb;
  localparam int PWIN = 100;
  localparam int RPLS = 4;
  logic                clk, reset, host_start, trig_start_n, run_mode, power_on_mode;
  logic                img_valid, img_ready, img_last, busy, done, oe_last, r_rm;
  logic [15:0]         tgt_khz, expect_id, r_khz;
  logic [3:0]          port_en, pwr_cmd, bad_id, bad_volt, oe, line_i, pwr, vok;
  logic [3:0]          rst_o, port_fail, dbg_o, r_en;
  logic [63:0]         port_id;
  logic [7:0]          img_data;
  gdps_pkg::gdps_err_e err_code;
  int                  bad_count, checks_done, cyc, gap, min_gap, hi_run, last_hi, seed;
  int                  done_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  gdps_seq #(.PWR_WIN_CYC(PWIN), .RST_PULSE_CYC(RPLS)) i_gdps_seq (
    .clk(clk), .reset(reset), .host_start(host_start), .trig_start_n(trig_start_n),
    .run_mode(run_mode), .power_on_mode(power_on_mode), .tgt_khz(tgt_khz),
    .port_en(port_en), .expect_id(expect_id), .port_id(port_id), .pwr_present(pwr),
    .volt_ok(vok), .img_valid(img_valid), .img_ready(img_ready), .img_data(img_data),
    .img_last(img_last), .single_wire_debug_line(dbg_o),
    .single_wire_debug_line_oe(oe), .single_wire_debug_line_sense(line_i),
    .tgt_reset(rst_o), .busy(busy), .done(done), .port_fail(port_fail),
    .err_code(err_code));
  gdps_tgt_model i_gdps_tgt_model (
    .clk(clk), .pwr_cmd(pwr_cmd), .bad_id(bad_id), .bad_volt(bad_volt),
    .id_val(expect_id), .line_oe(oe), .line_sense(line_i), .pwr_present(pwr),
    .volt_ok(vok), .port_id(port_id));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      end_sim();
    end
  end
  // edge spacing on port 0 debug line, reset high run length
  always @(posedge clk) begin
    if (busy === 1'b1 && oe[0] !== oe_last) begin
      if (gap < min_gap) min_gap <= gap;
      gap <= 1;
    end else gap <= (busy === 1'b1) ? gap + 1 : 1000000;
    oe_last <= oe[0];
    if (done === 1'b1) done_cnt <= done_cnt + 1;
    if (rst_o[0] === 1'b1) hi_run <= hi_run + 1;
    else if (hi_run != 0) begin
      last_hi <= hi_run;
      hi_run  <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int half(input logic [15:0] khz);
    int k;
    k = (khz < `GDPS_TGT_MIN_HZ / 1000) ? `GDPS_TGT_MIN_HZ / 1000 : int'(khz);
    return (`GDPS_TGT_RATIO * (`GDPS_SYS_HZ / 1000) + k - 1) / k;
  endfunction : half
  function automatic logic [3:0] exp_rst(input logic rm, input logic [3:0] en,
                                         input gdps_pkg::gdps_err_e e);
    return (rm || e != gdps_pkg::GDPS_OK) ? 4'h0 : en;
  endfunction : exp_rst
  task automatic end_sim();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic push(input logic [7:0] w);
    img_data  <= w;
    img_valid <= 1'b1;
    do @(posedge clk); while (img_ready !== 1'b1);
  endtask : push
  task automatic run(input logic src, input logic rm, input logic pm, input logic [15:0] khz,
                     input logic [3:0] en, input logic [3:0] pre, input logic [3:0] post,
                     input gdps_pkg::gdps_err_e ee, input logic [3:0] ef);
    int n, d0;
    run_mode      <= rm;
    power_on_mode <= pm;
    tgt_khz       <= khz;
    port_en       <= en;
    pwr_cmd       <= pre;
    img_last      <= 1'b0;
    repeat (50) @(posedge clk);
    if (ee == gdps_pkg::GDPS_OK) begin
      push(8'($random(seed)));
      push(8'($random(seed)));
    end
    img_valid <= 1'b0;
    img_last  <= 1'b1;
    min_gap   <= 1000000;
    d0 = done_cnt;
    if (src) host_start <= 1'b1;
    else trig_start_n <= 1'b0;
    @(posedge clk);
    host_start   <= 1'b0;
    repeat (3) @(posedge clk);
    trig_start_n <= 1'b1;
    pwr_cmd      <= post;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done_cnt == d0 && n < 40000);
    check({14'h0, err_code}, {14'h0, ee});
    check({12'h0, port_fail}, {12'h0, ef});
    repeat (10) @(posedge clk);
    check(16'(done_cnt - d0), 16'h1);
    check({12'h0, dbg_o}, 16'h0);
    check({12'h0, rst_o}, {12'h0, exp_rst(rm, en, ee)});
    if (rm && en[0] && ee == gdps_pkg::GDPS_OK) check(16'(last_hi >= RPLS), 16'h1);
    if (en[0] && ee == gdps_pkg::GDPS_OK) check(16'(min_gap >= half(khz)), 16'h1);
    $display("test done khz %0d ports %h", khz, en);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed          = 51707;
    reset         = 1'b1;
    host_start    = 1'b0;
    trig_start_n  = 1'b1;
    run_mode      = 1'b0;
    power_on_mode = 1'b0;
    tgt_khz       = 16'h0fa0;
    port_en       = 4'h0;
    expect_id     = 16'h5a3c;
    pwr_cmd       = 4'hf;
    bad_id        = 4'h0;
    bad_volt      = 4'h0;
    img_valid     = 1'b0;
    img_data      = 8'h00;
    img_last      = 1'b0;
    oe_last       = 1'b0;
    min_gap       = 1000000;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    run(1'b1, 1'b0, 1'b0, 16'd1000, 4'hf, 4'hf, 4'hf, gdps_pkg::GDPS_OK, 4'h0);
    run(1'b0, 1'b1, 1'b0, 16'd4000, 4'h5, 4'hf, 4'hf, gdps_pkg::GDPS_OK, 4'h0);
    run(1'b1, 1'b0, 1'b1, 16'd4000, 4'h3, 4'h0, 4'hf, gdps_pkg::GDPS_OK, 4'h0);
    run(1'b1, 1'b1, 1'b1, 16'd4000, 4'hf, 4'hf, 4'hf, gdps_pkg::GDPS_E_POWER, 4'hf);
    run(1'b1, 1'b0, 1'b1, 16'd4000, 4'h9, 4'h0, 4'h0, gdps_pkg::GDPS_E_POWER, 4'h9);
    bad_id <= 4'h2;
    run(1'b1, 1'b0, 1'b0, 16'd4000, 4'h2, 4'hf, 4'hf, gdps_pkg::GDPS_E_ID, 4'h2);
    bad_id   <= 4'h0;
    bad_volt <= 4'h8;
    run(1'b0, 1'b0, 1'b0, 16'd4000, 4'h8, 4'hf, 4'hf, gdps_pkg::GDPS_E_VOLT, 4'h8);
    bad_volt <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      r_rm  = 1'($random(seed));
      r_en  = 4'($random(seed)) | 4'h1;
      r_khz = 16'd2000 + 16'($random(seed) & 4095);
      run(i[0], r_rm, 1'b0, r_khz, r_en, 4'hf, 4'hf, gdps_pkg::GDPS_OK, 4'h0);
    end
    port_en    <= 4'h0;
    host_start <= 1'b1;
    repeat (3) @(posedge clk);
    host_start <= 1'b0;
    check({15'h0, busy}, 16'h0);
    $display("test done refused start");
    port_en  <= 4'h1;
    tgt_khz  <= 16'd20;
    img_last <= 1'b0;
    min_gap  <= 1000000;
    push(8'h80);
    img_valid  <= 1'b0;
    img_last   <= 1'b1;
    host_start <= 1'b1;
    @(posedge clk);
    host_start <= 1'b0;
    repeat (26000) @(posedge clk);
    check(16'(min_gap == half(16'd20)), 16'h1);
    $display("test done slow target");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    check({15'h0, busy}, 16'h0);
    check({8'h0, oe, rst_o}, 16'h0);
    end_sim();
  end
endmodule : tb
